// ---- logic/core_reset_seq.v ----
// reset sequencer: holds a core reset for a fixed count, then reports done
`include "host_cmd_sts_regs.vh"
module core_reset_seq (
    // clock and control
    input  wire       clk,
    input  wire       rst,
    input  wire       ce,
    // request and status
    input  wire       start,
    output wire       busy,
    output reg        done_pulse
);
    reg [7:0] cnt_r;
    // the count is cut to the counter width on purpose; it must be at least two
    localparam integer LOAD_CYC = `RESET_CYCLES;
    localparam [7:0]   LOAD     = LOAD_CYC[7:0];

    // count down; a restart while busy simply reloads
    // done fires one cycle early so the restore lands on the edge where busy falls
    always @(posedge clk) begin
        if (rst) begin
            cnt_r      <= 8'h00;
            done_pulse <= 1'b0;
        end else if (ce) begin
            done_pulse <= (cnt_r == 8'h02) && !start;
            if (start)
                cnt_r <= LOAD;
            else if (cnt_r != 8'h00)
                cnt_r <= cnt_r - 8'h01;
        end
    end
    assign busy = (cnt_r != 8'h00);
endmodule

// ---- logic/host_cmd_sts.v ----
// command, status and interrupt-enable registers of the host controller core
`include "host_cmd_sts_regs.vh"
module host_cmd_sts (
    // clock, reset, enable
    input  wire        clk,
    input  wire        rst,
    input  wire        ce,
    // register access port
    input  wire [7:0]  reg_addr,
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [31:0] reg_wdata,
    output reg  [31:0] reg_rdata,
    // frame index and port events from the core
    input  wire [13:0] frame_index,
    input  wire [2:0]  port_change,
    input  wire [2:0]  port_owner,
    input  wire [2:0]  force_port_resume,
    input  wire [2:0]  port_suspended,
    // controls to the core
    output wire        run_stop,
    output wire [1:0]  frame_list_size,
    output wire        core_reset,
    output wire        light_reset,
    output wire        ports_reset
);
    reg  [31:0] cmd_r;
    reg  [31:0] cmd_nxt;
    reg  [31:0] sts_r;
    reg  [31:0] sts_nxt;
    reg  [31:0] intr_r;
    reg  [13:0] fidx_prev_r;
    reg  [2:0]  chg_prev_r;
    reg  [2:0]  fpr_prev_r;
    reg         light_r;
    wire        seq_busy;
    wire        seq_done;
    wire        wr_cmd  = reg_wr && (reg_addr == `OFS_HOST_COMMAND);
    wire        wr_sts  = reg_wr && (reg_addr == `OFS_HOST_STATUS);
    wire        wr_intr = reg_wr && (reg_addr == `OFS_HOST_INTERRUPT_ENABLE);
    wire        hc_req  = wr_cmd && reg_wdata[`CMD_CONTROLLER_RESET_BIT];
    wire        lr_req  = wr_cmd && reg_wdata[`CMD_LIGHT_RESET_BIT] && `LIGHT_RESET_IMPL;
    reg  [13:0] idx_mask;
    reg         rollover;
    reg         pcd_event;
    wire [2:0]  port_evt;
    genvar      g;

    core_reset_seq u_seq (
        .clk        (clk),
        .rst        (rst),
        .ce         (ce),
        .start      (hc_req | lr_req),
        .busy       (seq_busy),
        .done_pulse (seq_done)
    );

    // index width by frame list size: 1024, 512, 256 entries
    always @* begin
        case (cmd_r[`CMD_FLS_LSB+1:`CMD_FLS_LSB])
            2'b00:   idx_mask = 14'h1FFF; // see R12
            2'b01:   idx_mask = 14'h0FFF;
            2'b10:   idx_mask = 14'h07FF;
            default: idx_mask = 14'h1FFF;
        endcase
    end

    // rollover: masked index went from nonzero to zero
    always @* begin
        rollover = ((fidx_prev_r & idx_mask) != 14'h0000) &&
                   ((frame_index & idx_mask) == 14'h0000); // see R8
    end

    // port change per port: owned-port change rise or resume rise on suspended port
    generate
        for (g = 0; g < `NUM_PORTS; g = g + 1) begin : g_port
            assign port_evt[g] = (port_change[g] && !chg_prev_r[g] && !port_owner[g]) ||
                (force_port_resume[g] && !fpr_prev_r[g] && port_suspended[g]); // see R9
        end
    endgenerate

    // any port raises the shared change event
    always @* begin
        pcd_event = |port_evt; // see R9
    end

    // command next value: writes take effect at once, reset bit self-clears
    always @* begin
        cmd_nxt = cmd_r;
        if (wr_cmd) begin
            cmd_nxt = reg_wdata; // see R1
            cmd_nxt[`CMD_LIGHT_RESET_BIT] = lr_req; // see R3
        end
        if (hc_req || lr_req)
            cmd_nxt[`CMD_RUN_STOP_BIT] = 1'b0;
        if (seq_done) begin
            cmd_nxt[`CMD_CONTROLLER_RESET_BIT] = 1'b0; // see R13
            cmd_nxt[`CMD_LIGHT_RESET_BIT] = 1'b0;
        end
    end

    // status next value: set beats clear so no event is lost
    always @* begin
        sts_nxt = sts_r;
        if (wr_sts)
            sts_nxt = sts_r & ~reg_wdata; // see R6
        if (rollover && !seq_busy)
            sts_nxt[`STS_FLR_BIT] = 1'b1;
        if (pcd_event && !seq_busy)
            sts_nxt[`STS_PCD_BIT] = 1'b1;
        // only event bits exist; no transaction outcome lands here
        sts_nxt = sts_nxt & ((32'h1 << `STS_FLR_BIT) | (32'h1 << `STS_PCD_BIT)); // see R7
    end

    // register state; a completed controller reset restores defaults
    always @(posedge clk) begin
        if (rst) begin
            cmd_r       <= `CMD_RESET_VAL;
            sts_r       <= `STS_RESET_VAL;
            intr_r      <= `INTR_RESET_VAL;
            fidx_prev_r <= 14'h0000;
            chg_prev_r  <= 3'b000;
            fpr_prev_r  <= 3'b000;
            light_r     <= 1'b0;
        end else if (ce) begin
            fidx_prev_r <= frame_index;
            chg_prev_r  <= port_change;
            fpr_prev_r  <= force_port_resume;
            if (hc_req || lr_req)
                light_r <= lr_req && !hc_req;
            if (seq_done) begin
                cmd_r  <= `CMD_RESET_VAL; // see R14
                sts_r  <= `STS_RESET_VAL; // see R14
                intr_r <= `INTR_RESET_VAL;
            end else begin
                cmd_r <= cmd_nxt;
                sts_r <= sts_nxt;
                if (wr_intr)
                    intr_r <= reg_wdata; // see R11
            end
        end
    end

    // read mux, registered; unmapped addresses read zero
    always @(posedge clk) begin
        if (rst) begin
            reg_rdata <= 32'h00000000;
        end else if (ce && reg_rd) begin
            case (reg_addr)
                `OFS_HOST_COMMAND:          reg_rdata <= cmd_r;
                `OFS_HOST_STATUS:           reg_rdata <= sts_r;
                `OFS_HOST_INTERRUPT_ENABLE: reg_rdata <= intr_r;
                default:                    reg_rdata <= 32'h00000000;
            endcase
        end
    end

    // controls to the core; a light reset leaves ports and routing alone
    assign run_stop        = cmd_r[`CMD_RUN_STOP_BIT] && !seq_busy; // see R5
    assign frame_list_size = cmd_r[`CMD_FLS_LSB+1:`CMD_FLS_LSB];
    assign core_reset      = seq_busy; // see R4
    assign light_reset     = seq_busy && light_r; // see R2
    assign ports_reset     = seq_busy && !light_r; // see R2
endmodule

// ---- logic/host_cmd_sts_regs.vh ----
// register offsets, field positions, reset values and timing counts for the command/status group
// Notes on behaviour
// R1: every command write is acted on immediately; a write on the edge where the reset sequence ends is dropped
// R2: light reset resets core, keeps ports and routing
// R3: light reset bit reads zero when not implemented
// R4: controller reset bit resets the host controller
// R5: run is one; schedule runs only then
// R6: status events clear on written one only
// R7: status holds no transaction outcomes
// R8: rollover set when frame index wraps
// R9: port change on owned-port change or resume
// R10: software writes reserved bits with reset values
// R11: interrupt enable is storage with no function
// R12: index width follows configured frame list size
// R13: controller reset bit self-clears when done
// R14: controller reset restores command and status defaults
`ifndef HOST_CMD_STS_REGS_VH
`define HOST_CMD_STS_REGS_VH
`define OFS_HOST_COMMAND          8'h20
`define OFS_HOST_STATUS           8'h24
`define OFS_HOST_INTERRUPT_ENABLE 8'h28
`define CMD_RESET_VAL             32'h00080B00
`define STS_RESET_VAL             32'h00000000
`define INTR_RESET_VAL            32'h00000000
`define CMD_RUN_STOP_BIT          0
`define CMD_CONTROLLER_RESET_BIT  1
`define CMD_FLS_LSB               2
`define CMD_LIGHT_RESET_BIT       7
`define STS_PCD_BIT               2
`define STS_FLR_BIT               3
`define LIGHT_RESET_IMPL          1'b1
`define RESET_TIME_NS             80
`define CLK_PERIOD_NS             5
`define RESET_CYCLES              ((`RESET_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define NUM_PORTS                 3
`endif

// ---- testbench/host_cmd_sts_sva.sv ----
// timing checks on the command/status register ports
module host_cmd_sts_sva (
    // clock, reset, enable
    input wire        clk,
    input wire        rst,
    input wire        ce,
    // register access port
    input wire [7:0]  reg_addr,
    input wire        reg_wr,
    input wire        reg_rd,
    input wire [31:0] reg_wdata,
    input wire [31:0] reg_rdata,
    // frame index and port events
    input wire [13:0] frame_index,
    input wire [2:0]  port_change,
    input wire [2:0]  port_owner,
    input wire [2:0]  force_port_resume,
    input wire [2:0]  port_suspended,
    // controls to the core
    input wire        run_stop,
    input wire [1:0]  frame_list_size,
    input wire        core_reset,
    input wire        light_reset,
    input wire        ports_reset
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // a command write taken on this edge
    wire cw = ce && reg_wr && reg_addr == 8'h20;
    wire plain = !reg_wdata[1] && !reg_wdata[7] && !core_reset;
    a_hard_reset_start: assert property (
        cw && reg_wdata[1] |=> core_reset && ports_reset)
        else $error("controller reset not started");
    a_light_reset_only: assert property (
        cw && reg_wdata[7] && !reg_wdata[1] && !core_reset |=> light_reset && !ports_reset)
        else $error("light reset touched ports");
    a_stop_in_reset: assert property (core_reset |-> !run_stop)
        else $error("running during reset");
    a_cmd_write_acts: assert property (
        cw && plain |=> run_stop == $past(reg_wdata[0])
        && frame_list_size == $past(reg_wdata[3:2])) else $error("command ignored");
    // the sequence holds the core reset for exactly sixteen cycles
    a_reset_span: assert property (
        $rose(core_reset) |-> core_reset[*8] ##1 core_reset[*8] ##1 !core_reset)
        else $error("reset span wrong");
    a_reset_restores: assert property (
        $fell(core_reset) && $past(ports_reset) |-> frame_list_size == 2'h0 && !run_stop)
        else $error("defaults lost");
    a_intr_inert: assert property (
        ce && reg_wr && reg_addr == 8'h28 && !core_reset
        |=> $stable(run_stop) && $stable(frame_list_size)) else $error("intr acted");
    a_status_clean: assert property (
        ce && reg_rd && reg_addr == 8'h24
        |=> reg_rdata[31:4] == 28'h0 && reg_rdata[1:0] == 2'h0) else $error("sts junk");
    a_unmapped_zero: assert property (ce && reg_rd && reg_addr == 8'h30 |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    c_hard: cover property (cw && reg_wdata[1]);
    c_light: cover property (cw && reg_wdata[7]);
    c_done: cover property ($fell(core_reset));
endmodule

bind host_cmd_sts host_cmd_sts_sva chk (.*);

// ---- testbench/tb_top.sv ----
// self-checking bench for the command/status register group
`include "host_cmd_sts_regs.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk = 0, rst = 1, ce = 1, reg_wr = 0, reg_rd = 0;
    logic [7:0]  reg_addr = 8'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic [13:0] frame_index = 14'h0;
    logic [2:0]  port_change = 3'h0, port_owner = 3'h0, force_port_resume = 3'h0;
    logic [2:0]  port_suspended = 3'h0;
    logic        run_stop, core_reset, light_reset, ports_reset;
    logic [1:0]  frame_list_size;
    int          fail_count = 0, total_checks = 0, n;
    always #2.5 clk = ~clk;
    host_cmd_sts dut (.*);
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_wr <= 1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 0;
    endtask
    // read data is registered, so look one step after the taking edge
    task automatic rc(input logic [7:0] a, input logic [31:0] e, input string s);
        @(posedge clk);
        reg_rd <= 1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 0;
        #1 chk(s, e, reg_rdata);
    endtask
    task automatic fi(input logic [13:0] a, input logic [13:0] b);
        @(posedge clk) frame_index <= a;
        @(posedge clk) frame_index <= b;
    endtask
    // bounded wait for the reset sequence; sampled off the edge, its length is checked too
    task automatic wait_done;
        n = 0;
        while (core_reset !== 1'b0 && n < 100) begin
            @(posedge clk);
            #1 n++;
        end
        if (n == 100) begin
            fail_count++;
            $display("unexpected reset wait expected done seen timeout");
            complete_run;
        end else begin
            chk("reset span", `RESET_CYCLES, n);
        end
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst <= 0;
        rc(8'h20, `CMD_RESET_VAL, "cmd");
        rc(8'h24, 32'h0, "sts");
        rc(8'h28, 32'h0, "intr");
        fi(14'h0FFF, 14'h1000);
        rc(8'h24, 32'h0, "sts fls0");
        wr(8'h20, 32'h00080B05);
        rc(8'h20, 32'h00080B05, "cmd");
        chk("run", 32'h1, {31'h0, run_stop});
        chk("fls", 32'h1, {30'h0, frame_list_size});
        fi(14'h0FFF, 14'h1000);
        rc(8'h24, 32'h8, "flr");
        wr(8'h24, 32'h0);
        rc(8'h24, 32'h8, "flr kept");
        wr(8'h24, 32'h8);
        rc(8'h24, 32'h0, "flr clr");
        @(posedge clk) port_owner <= 3'h1;
        port_change <= 3'h1;
        rc(8'h24, 32'h0, "pcd owned");
        @(posedge clk) port_change <= 3'h3;
        rc(8'h24, 32'h4, "pcd");
        wr(8'h24, 32'h4);
        rc(8'h24, 32'h0, "pcd clr");
        @(posedge clk) port_suspended <= 3'h4;
        force_port_resume <= 3'h4;
        rc(8'h24, 32'h4, "pcd resume");
        wr(8'h24, 32'h4);
        wr(8'h20, 32'h00080B09);
        fi(14'h07FF, 14'h0800);
        rc(8'h24, 32'h8, "flr 256");
        wr(8'h28, 32'hFFFFFFFF);
        rc(8'h28, 32'hFFFFFFFF, "intr rw");
        chk("run", 32'h1, {31'h0, run_stop});
        // with the enable low a write must leave every register alone
        @(posedge clk) ce <= 1'b0;
        wr(8'h28, 32'h00000000);
        @(posedge clk) ce <= 1'b1;
        rc(8'h28, 32'hFFFFFFFF, "intr frozen");
        rc(8'h30, 32'h0, "unmapped");
        wr(8'h20, 32'h00080B81);
        #1 chk("light", 32'h1, {31'h0, light_reset});
        chk("ports", 32'h0, {31'h0, ports_reset});
        wait_done;
        rc(8'h24, 32'h0, "sts after light");
        fi(14'h3FFF, 14'h0000);
        rc(8'h24, 32'h8, "flr again");
        wr(8'h20, 32'h00080B03);
        #1 chk("hard", 32'h1, {31'h0, ports_reset});
        chk("light off", 32'h0, {31'h0, light_reset});
        chk("run in reset", 32'h0, {31'h0, run_stop});
        wait_done;
        rc(8'h20, `CMD_RESET_VAL, "cmd after");
        rc(8'h24, 32'h0, "sts after");
        rc(8'h28, 32'h0, "intr after");
        complete_run;
    end
endmodule
